// ### verilog/seq_pkg.sv
// Constants and carrier types for the program sequencer core
// Function
// - 3-bit upper offset plus accumulator forms offset
// - Push program counter on interrupt, call, lookup
// - Eight identical program-counter-wide stack entries
// - Overflow silently overwrites older stack entries
// - Call at pointer seven wraps, overwrites entry zero
// - 3-bit stack pointer, readable into accumulator
// - Context save captures pointer, flags, A, B
// - Context save used only by interrupt entry/return
// - Skip flag saved across interrupt entry
// - Counter advances by length or loads target
// - Page field bit 7 up, offset bits 6-0
// - Offset 127 rolls into next page offset 0
// - RAM pointer: group, file, digit selectors
// - Digit selector picks port bit for bit ops
// - 10-bit ROM words, 128-word pages
// - Interrupt vectors in page 1, even addresses 0x80 to 0x8e
// - Page two call targets 0x100 to 0x17f
// - Table lookup reads ROM bits 7 to 0
// - 4-bit accumulator, low part of indirect offset
package seq_pkg;

  localparam int PC_W        = 13;
  localparam int OFS_W       = 7;
  localparam int PAGE_W      = PC_W - OFS_W;
  localparam int SP_W        = 3;
  localparam int DEPTH       = 8;
  localparam int ROM_W       = 10;
  localparam int UPPER_W     = 3;
  localparam int ACC_W       = 4;
  localparam int GRP_W       = 1;
  localparam int FILE_W      = 4;
  localparam int DIGIT_W     = 4;
  localparam int VEC_W       = 3;
  localparam int TABLE_W     = 8;

  localparam logic [SP_W-1:0]   SP_RESET    = 3'h7;
  localparam logic [PC_W-1:0]   PC_RESET    = 13'h0000;
  localparam logic [PAGE_W-1:0] VEC_PAGE    = 6'h01;
  localparam logic [PAGE_W-1:0] CALL2_PAGE  = 6'h02;
  localparam logic [OFS_W-1:0]  OFS_LAST    = 7'h7f;

  typedef enum logic [3:0] {
    OP_NONE    = 4'h0,
    OP_STEP    = 4'h1,
    OP_JUMP    = 4'h2,
    OP_CALL    = 4'h3,
    OP_CALL2   = 4'h4,
    OP_BRA_ACC = 4'h5,
    OP_CALL_ACC= 4'h6,
    OP_TABLE   = 4'h7,
    OP_RET     = 4'h8,
    OP_IRET    = 4'h9,
    OP_IRQ     = 4'ha
  } seq_op_e;

  typedef struct packed {
    logic [GRP_W-1:0]   group;
    logic [FILE_W-1:0]  file;
    logic [DIGIT_W-1:0] digit;
  } ram_ptr_s;

  typedef struct packed {
    ram_ptr_s           ptr;
    logic               carry;
    logic               skip;
    logic [ACC_W-1:0]   acc;
    logic [ACC_W-1:0]   breg;
  } context_s;

  typedef struct packed {
    seq_op_e            op;
    logic [1:0]         length;
    logic [PC_W-1:0]    target;
    logic [OFS_W-1:0]   call2_ofs;
    logic [PAGE_W-1:0]  ind_page;
    logic [VEC_W-1:0]   vector;
  } seq_cmd_s;

endpackage : seq_pkg

// ### verilog/return_stack.sv
// Eight-entry return stack with wrapping pointer
`timescale 1ns/100ps
module return_stack #(
  parameter int DEPTH = seq_pkg::DEPTH,
  parameter int W     = seq_pkg::PC_W
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_wake,
  input  wire logic                      i_push,
  input  wire logic                      i_pop,
  input  wire logic [W-1:0]              i_data,
  output logic      [W-1:0]              o_top,
  output logic      [seq_pkg::SP_W-1:0]  o_pointer
);

  logic [W-1:0]             entry_reg [DEPTH];
  logic [seq_pkg::SP_W-1:0] sp_reg;
  logic [seq_pkg::SP_W-1:0] sp_next;

  assign sp_next   = sp_reg + seq_pkg::SP_W'(1);
  assign o_top     = entry_reg[sp_reg];
  assign o_pointer = sp_reg;

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      sp_reg <= seq_pkg::SP_RESET;
    else if (i_wake)
      sp_reg <= seq_pkg::SP_RESET;
    else if (i_push)
      sp_reg <= sp_next;
    else if (i_pop)
      sp_reg <= sp_reg - seq_pkg::SP_W'(1);
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        entry_reg[i] <= '0;
    end
    else if (i_push && !i_wake)
      entry_reg[sp_next] <= i_data;
  end

endmodule : return_stack

// ### verilog/program_sequencer_stack.sv
// Program counter, stack, context save and data pointer sequencer
`timescale 1ns/100ps
module program_sequencer_stack (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_resetn,
  input  wire logic                          i_wake,
  input  wire logic                          i_cmd_valid,
  input  wire seq_pkg::seq_cmd_s             i_cmd,
  input  wire logic [seq_pkg::ROM_W-1:0]     i_rom_data,
  input  wire seq_pkg::context_s             i_context,
  input  wire logic                          i_skip_set,
  input  wire logic                          i_skip_clr,
  input  wire logic                          i_upper_we,
  input  wire logic [seq_pkg::UPPER_W-1:0]   i_upper_data,
  input  wire logic                          i_acc_we,
  input  wire logic [seq_pkg::ACC_W-1:0]     i_acc_data,
  input  wire logic                          i_ptr_we,
  input  wire seq_pkg::ram_ptr_s             i_ptr_data,
  input  wire logic                          i_sp_to_acc,
  output logic      [seq_pkg::PC_W-1:0]      o_program_counter,
  output logic      [seq_pkg::PAGE_W-1:0]    o_page_field,
  output logic      [seq_pkg::OFS_W-1:0]     o_offset_field,
  output logic      [seq_pkg::SP_W-1:0]      o_stack_pointer,
  output logic      [seq_pkg::ACC_W-1:0]     o_acc,
  output logic                               o_skip,
  output seq_pkg::ram_ptr_s                  o_ram_pointer,
  output logic      [seq_pkg::DIGIT_W-1:0]   o_port_bit_sel,
  output logic      [seq_pkg::TABLE_W-1:0]   o_table_data,
  output logic                               o_table_valid,
  output logic                               o_busy,
  output logic                               o_restore_valid,
  output seq_pkg::context_s                  o_restore
);

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_FETCH = 2'b01,
    ST_BACK  = 2'b11
  } seq_state_e;

  seq_state_e                       state_reg;
  logic [seq_pkg::PC_W-1:0]         pc_reg;
  logic [seq_pkg::PC_W-1:0]         pc_next;
  logic [seq_pkg::UPPER_W-1:0]      upper_reg;
  logic [seq_pkg::ACC_W-1:0]        acc_reg;
  logic                             skip_reg;
  seq_pkg::ram_ptr_s                ptr_reg;
  seq_pkg::context_s                save_reg;
  logic [seq_pkg::TABLE_W-1:0]      table_reg;
  logic                             table_vld_reg;
  logic                             restore_vld_reg;
  logic [seq_pkg::OFS_W-1:0]        ind_ofs;
  logic                             run;
  logic                             push;
  logic                             pop;
  logic [seq_pkg::PC_W-1:0]         push_data;
  logic [seq_pkg::PC_W-1:0]         stack_top;
  logic [seq_pkg::SP_W-1:0]         sp;

  assign run     = (state_reg == ST_RUN) && i_cmd_valid && !i_wake;
  assign ind_ofs = {upper_reg, acc_reg};

  // Stack traffic
  always_comb
  begin
    push      = 1'b0;
    pop       = 1'b0;
    push_data = pc_reg + seq_pkg::PC_W'(i_cmd.length);
    if (run)
    begin
      case (i_cmd.op)
        seq_pkg::OP_CALL,
        seq_pkg::OP_CALL2,
        seq_pkg::OP_CALL_ACC: push = 1'b1;
        seq_pkg::OP_TABLE:    push = 1'b1;
        seq_pkg::OP_IRQ:
        begin
          push      = 1'b1;
          push_data = pc_reg;
        end
        seq_pkg::OP_RET,
        seq_pkg::OP_IRET:     pop = 1'b1;
        default: ;
      endcase
    end
    else if (state_reg == ST_BACK)
      pop = 1'b1;
  end

  return_stack #(
    .DEPTH (seq_pkg::DEPTH),
    .W     (seq_pkg::PC_W)
  ) u_stack (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_wake     (i_wake),
    .i_push     (push),
    .i_pop      (pop),
    .i_data     (push_data),
    .o_top      (stack_top),
    .o_pointer  (sp)
  );

  // Next program counter
  always_comb
  begin
    pc_next = pc_reg;
    if (run)
    begin
      case (i_cmd.op)
        seq_pkg::OP_STEP:
          pc_next = pc_reg + seq_pkg::PC_W'(i_cmd.length);
        seq_pkg::OP_JUMP,
        seq_pkg::OP_CALL:
          pc_next = i_cmd.target;
        seq_pkg::OP_CALL2:
          pc_next = {seq_pkg::CALL2_PAGE, i_cmd.call2_ofs};
        seq_pkg::OP_BRA_ACC,
        seq_pkg::OP_CALL_ACC:
          pc_next = {i_cmd.ind_page, ind_ofs};
        seq_pkg::OP_TABLE:
          pc_next = {pc_reg[seq_pkg::PC_W-1:seq_pkg::OFS_W], ind_ofs};
        seq_pkg::OP_RET,
        seq_pkg::OP_IRET:
          pc_next = stack_top;
        seq_pkg::OP_IRQ:
          pc_next = {seq_pkg::VEC_PAGE,
                     {(seq_pkg::OFS_W-seq_pkg::VEC_W-1){1'b0}},
                     i_cmd.vector, 1'b0};
        default: pc_next = pc_reg;
      endcase
    end
    else if (state_reg == ST_BACK)
      pc_next = stack_top;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      pc_reg <= seq_pkg::PC_RESET;
    else if (i_wake)
      pc_reg <= seq_pkg::PC_RESET;
    else
      pc_reg <= pc_next;
  end

  // Table lookup sequence
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      state_reg <= ST_RUN;
    else if (i_wake)
      state_reg <= ST_RUN;
    else
    begin
      case (state_reg)
        ST_RUN:
          if (run && i_cmd.op == seq_pkg::OP_TABLE)
            state_reg <= ST_FETCH;
        ST_FETCH: state_reg <= ST_BACK;
        ST_BACK:  state_reg <= ST_RUN;
        default:  state_reg <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      table_reg     <= '0;
      table_vld_reg <= 1'b0;
    end
    else
    begin
      table_vld_reg <= (state_reg == ST_FETCH);
      if (state_reg == ST_FETCH)
        table_reg <= i_rom_data[seq_pkg::TABLE_W-1:0];
    end
  end

  // Upper offset register
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      upper_reg <= '0;
    else if (i_upper_we)
      upper_reg <= i_upper_data;
  end

  // Accumulator, skip flag and data pointer, restored on interrupt return
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      acc_reg <= '0;
    else if (run && i_cmd.op == seq_pkg::OP_IRET)
      acc_reg <= save_reg.acc;
    else if (i_sp_to_acc)
      acc_reg <= {1'b0, sp};
    else if (i_acc_we)
      acc_reg <= i_acc_data;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      skip_reg <= 1'b0;
    else if (run && i_cmd.op == seq_pkg::OP_IRET)
      skip_reg <= save_reg.skip;
    else if (i_skip_set)
      skip_reg <= 1'b1;
    else if (i_skip_clr)
      skip_reg <= 1'b0;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ptr_reg <= '0;
    else if (run && i_cmd.op == seq_pkg::OP_IRET)
      ptr_reg <= save_reg.ptr;
    else if (i_ptr_we)
      ptr_reg <= i_ptr_data;
  end

  // Single-stage context save, interrupt only
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      save_reg <= '0;
    else if (run && i_cmd.op == seq_pkg::OP_IRQ)
    begin
      save_reg       <= i_context;
      save_reg.ptr   <= ptr_reg;
      save_reg.acc   <= acc_reg;
      save_reg.skip  <= skip_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      restore_vld_reg <= 1'b0;
    else
      restore_vld_reg <= run && i_cmd.op == seq_pkg::OP_IRET;
  end

  assign o_program_counter = pc_reg;
  assign o_page_field      = pc_reg[seq_pkg::PC_W-1:seq_pkg::OFS_W];
  assign o_offset_field    = pc_reg[seq_pkg::OFS_W-1:0];
  assign o_stack_pointer   = sp;
  assign o_acc             = acc_reg;
  assign o_skip            = skip_reg;
  assign o_ram_pointer     = ptr_reg;
  assign o_port_bit_sel    = ptr_reg.digit;
  assign o_table_data      = table_reg;
  assign o_table_valid     = table_vld_reg;
  assign o_busy            = (state_reg != ST_RUN);
  assign o_restore_valid   = restore_vld_reg;
  assign o_restore         = save_reg;

endmodule : program_sequencer_stack

// ### dv/rom_model.sv
// Combinational program memory model
`timescale 1ns/100ps
module rom_model (
  input  wire logic [12:0] i_addr,
  output logic      [9:0]  o_data
);
  // Address-derived words keep lookups within any 256-word span distinct
  assign o_data = {i_addr[1:0], i_addr[7:0] ^ 8'h5a};
endmodule : rom_model

// ### dv/seq_checker.sv
// Port assertions for the program sequencer
`timescale 1ns/100ps
module seq_checker (
  input wire logic              i_core_clk,
  input wire logic              i_resetn,
  input wire logic              i_wake,
  input wire logic              i_cmd_valid,
  input wire seq_pkg::seq_cmd_s i_cmd,
  input wire logic [12:0]       o_program_counter,
  input wire logic [5:0]        o_page_field,
  input wire logic [6:0]        o_offset_field,
  input wire logic [2:0]        o_stack_pointer,
  input wire logic              o_table_valid,
  input wire logic              o_busy
);
  seq_pkg::seq_op_e op;
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  // Operation taken at this edge
  assign op = (i_cmd_valid && !o_busy && !i_wake) ? i_cmd.op
                                                   : seq_pkg::OP_NONE;
  chk_page_split: assert property (
    {o_page_field, o_offset_field} == o_program_counter)
    else $error("bad page split");
  chk_step_adv: assert property (
    op == seq_pkg::OP_STEP |=> o_program_counter ==
      $past(o_program_counter) + $past(i_cmd.length))
    else $error("bad step");
  chk_call_push: assert property (
    op == seq_pkg::OP_CALL |=> o_program_counter == $past(i_cmd.target)
      && o_stack_pointer == $past(o_stack_pointer) + 3'h1)
    else $error("bad call");
  chk_ret_pop: assert property (
    op == seq_pkg::OP_RET |=>
      o_stack_pointer == $past(o_stack_pointer) - 3'h1)
    else $error("bad return");
  chk_irq_vec: assert property (
    op == seq_pkg::OP_IRQ |=> o_program_counter ==
      {seq_pkg::VEC_PAGE, 3'h0, $past(i_cmd.vector), 1'b0})
    else $error("bad vector");
  chk_call2_tgt: assert property (
    op == seq_pkg::OP_CALL2 |=> o_program_counter ==
      {seq_pkg::CALL2_PAGE, $past(i_cmd.call2_ofs)})
    else $error("bad page two call");
  chk_table_seq: assert property (
    op == seq_pkg::OP_TABLE |=> o_busy ##1 o_table_valid ##1
      (o_program_counter ==
        $past(o_program_counter, 3) + $past(i_cmd.length, 3)))
    else $error("bad lookup");
  chk_wake_init: assert property (
    i_wake |=> o_stack_pointer == seq_pkg::SP_RESET
      && o_program_counter == seq_pkg::PC_RESET)
    else $error("bad wake");
  cover property (op == seq_pkg::OP_TABLE);
  cover property (op == seq_pkg::OP_IRQ);
  cover property (op == seq_pkg::OP_CALL && o_stack_pointer == 3'h7);
endmodule : seq_checker

bind program_sequencer_stack seq_checker u_chk (
  .i_core_clk, .i_resetn, .i_wake, .i_cmd_valid, .i_cmd,
  .o_program_counter, .o_page_field, .o_offset_field,
  .o_stack_pointer, .o_table_valid, .o_busy
);

// ### dv/tb_program_sequencer_stack.sv
// Self-checking bench for the program sequencer core
`timescale 1ns/100ps
module tb_program_sequencer_stack;
  logic              i_core_clk = 1'b0, i_resetn = 1'b0, i_wake = 1'b0;
  logic              i_cmd_valid = 1'b0, i_skip_set = 1'b0;
  logic              i_skip_clr = 1'b0, i_upper_we = 1'b0;
  logic              i_acc_we = 1'b0, i_ptr_we = 1'b0, i_sp_to_acc = 1'b0;
  logic              o_skip, o_table_valid, o_busy, o_restore_valid;
  logic [2:0]        i_upper_data = 3'h0, o_stack_pointer;
  logic [3:0]        i_acc_data = 4'h0, o_acc, o_port_bit_sel;
  logic [5:0]        o_page_field;
  logic [6:0]        o_offset_field;
  logic [7:0]        o_table_data;
  logic [9:0]        i_rom_data;
  logic [12:0]       o_program_counter;
  seq_pkg::seq_cmd_s i_cmd = '0;
  seq_pkg::context_s i_context = '0, o_restore;
  seq_pkg::ram_ptr_s i_ptr_data = '0, o_ram_pointer;
  int                m_pc, m_sp, m_acc, m_up, m_skip, m_ptr, m_stk[8];
  int                s_ptr, s_acc, s_skip, s_cb, r, i, err_count, n_checks;
  int                q_tab[$];

  rom_model u_rom (.i_addr(o_program_counter), .o_data(i_rom_data));
  program_sequencer_stack DUT (
    .i_core_clk, .i_resetn, .i_wake, .i_cmd_valid, .i_cmd, .i_rom_data,
    .i_context, .i_skip_set, .i_skip_clr, .i_upper_we, .i_upper_data,
    .i_acc_we, .i_acc_data, .i_ptr_we, .i_ptr_data, .i_sp_to_acc,
    .o_program_counter, .o_page_field, .o_offset_field, .o_stack_pointer,
    .o_acc, .o_skip, .o_ram_pointer, .o_port_bit_sel, .o_table_data,
    .o_table_valid, .o_busy, .o_restore_valid, .o_restore
  );
  always #5 i_core_clk = ~i_core_clk;

  task automatic check(input string w, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %0h seen %0h", w, e, s);
    end
  endtask : check

  task automatic step;
    @(posedge i_core_clk);
    #1;
    check("pc", o_program_counter, m_pc);
    check("sp", o_stack_pointer, m_sp);
    check("acc", o_acc, m_acc);
    check("skip", o_skip, m_skip);
    check("ptr", o_ram_pointer, m_ptr);
    check("bitsel", o_port_bit_sel, m_ptr & 'hf);
  endtask : step

  function automatic void push(input int v);
    m_sp = (m_sp + 1) & 7;
    m_stk[m_sp] = v;
  endfunction : push

  function automatic int pop();
    pop = m_stk[m_sp];
    m_sp = (m_sp - 1) & 7;
  endfunction : pop

  task automatic strobes(input logic [6:0] s);
    {i_skip_set, i_skip_clr, i_upper_we, i_acc_we, i_ptr_we, i_sp_to_acc,
     i_wake} = s;
  endtask : strobes

  task automatic side(input logic [6:0] s);
    i_cmd_valid = 1'b0;
    strobes(s);
    i_upper_data = 3'($urandom);
    i_acc_data = 4'($urandom);
    i_ptr_data = 9'($urandom);
    m_skip = s[6] ? 1 : s[5] ? 0 : m_skip;
    m_up = s[4] ? i_upper_data : m_up;
    m_acc = s[1] ? m_sp : s[3] ? i_acc_data : m_acc;
    m_ptr = s[2] ? i_ptr_data : m_ptr;
    m_pc = s[0] ? 0 : m_pc;
    m_sp = s[0] ? 7 : m_sp;
    step;
  endtask : side

  task automatic issue(input int op, input int len, input int tgt);
    int nx;
    int ofs;
    nx = (m_pc + len) & 'h1fff;
    ofs = m_up << 4 | m_acc;
    i_cmd_valid = 1'b1;
    strobes(7'h00);
    i_cmd = {seq_pkg::seq_op_e'(op), 2'(len), 13'(tgt), 7'(tgt),
             6'(tgt >> 7), 3'(tgt)};
    i_context = 19'($urandom);
    if (op == 7)
      q_tab.push_back(((m_pc & 'h1f80 | ofs) ^ 'h5a) & 'hff);
    if (op == 7)
      m_stk[(m_sp + 1) & 7] = nx;
    if (op inside {3, 4, 6})
      push(nx);
    if (op == 10)
    begin
      push(m_pc);
      {s_ptr, s_acc, s_skip} = {m_ptr, m_acc, m_skip};
      s_cb = {i_context.carry, i_context.breg};
    end
    case (op)
      1, 7: m_pc = nx;
      2, 3: m_pc = tgt;
      4: m_pc = 'h100 | tgt & 'h7f;
      5, 6: m_pc = tgt & 'h1f80 | ofs;
      8, 9: m_pc = pop();
      10: m_pc = 'h80 + 2 * (tgt & 7);
      default: ;
    endcase
    if (op == 9)
      {m_ptr, m_acc, m_skip} = {s_ptr, s_acc, s_skip};
    if (op == 7)
    begin
      @(posedge i_core_clk);
      #1;
      // Ignored while the lookup is busy
      i_cmd.op = seq_pkg::OP_JUMP;
      check("busy", o_busy, 1'b1);
      @(posedge i_core_clk);
      #1;
      check("tvalid", o_table_valid, 1'b1);
      check("tdata", o_table_data, q_tab.pop_front());
    end
    step;
    if (op == 9)
      check("rvalid", o_restore_valid, 1'b1);
    if (op == 9)
      check("rctx", {o_restore.carry, o_restore.breg}, s_cb);
  endtask : issue

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    r = $urandom(32'h38fb6b3d);
    m_sp = 7;
    repeat (3) @(posedge i_core_clk);
    #1;
    i_resetn = 1'b1;
    side(7'h5e);
    side(7'h60);
    side(7'h20);
    issue(2, 1, 'h7e);
    repeat (3) issue(1, 1, 0);
    repeat (9) issue(3, 1 + $urandom % 3, $urandom % 'h2000);
    repeat (9) issue(8, 1, 0);
    issue(10, 1, 3);
    for (i = 0; i < 400; i++)
    begin
      r = $urandom % 14;
      if (r < 11)
        issue(r, 1 + $urandom % 3, $urandom % 'h2000);
      else
        side({6'($urandom), 1'b0});
    end
    side(7'h01);
    side(7'h00);
    i_resetn = 1'b0;
    {m_pc, m_acc, m_skip, m_ptr} = '0;
    m_sp = 7;
    step;
    i_resetn = 1'b1;
    issue(3, 1, 'h1abc);
    tally_and_finish;
  end
endmodule : tb_program_sequencer_stack
